// [dv/drp_por_properties.sv]
// Checker for the reset sequencer's outputs.
// Assumes a bind by name onto the sequencer.
`timescale 1ns/1ps
module drp_por_properties (
   input wire logic clk, nrst, standby_low, main_low, main_reset_n_in,
   input wire logic standby_reset_n, main_reset_n_out, main_reset_n_oe_n);
   // One domain; slack of 7 covers the input synchronisers
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_stby_follow: assert property (standby_low [*7] |-> !standby_reset_n)
      else $error("standby free");
   a_stby_hold: assert property ($fell(standby_low) |-> !standby_reset_n [*8])
      else $error("standby hold");
   a_dip_reasserts: assert property ($rose(standby_low) |-> ##[1:7] !standby_reset_n)
      else $error("dip missed");
   a_main_follow: assert property (main_low [*7] |-> !main_reset_n_oe_n)
      else $error("main free");
   a_main_hold: assert property ($fell(main_low) |-> !main_reset_n_oe_n [*8])
      else $error("main hold");
   a_main_trails: assert property ($rose(standby_reset_n) |-> !main_reset_n_oe_n [*8])
      else $error("main early");
   a_pin_request: assert property (!main_reset_n_in [*7] |-> !main_reset_n_oe_n)
      else $error("pin missed");
   a_pin_drive: assert property (main_reset_n_out == 1'h0)
      else $error("pin high");
   c_stby_up: cover property ($rose(standby_reset_n));
   c_main_up: cover property ($rose(main_reset_n_oe_n));
   c_pin_low: cover property ($fell(main_reset_n_in));
endmodule

// [dv/drp_sys_model.sv]
// Model of outside logic sharing the main reset pin.
// Assumes the block's own drive is left out of the sensed level.
`timescale 1ns/1ps
module drp_sys_model (
   // Outside request, high to pull the pin low
   input wire logic req,
   // Sensed pin level, own drive left out
   output logic main_reset_n_in
);
   // Pull-up gives high whenever nobody outside pulls
   assign main_reset_n_in = !req;
endmodule

// [dv/tb.sv]
// Bench: power-up with a standby dip, then a pin request.
// Assumes a 20 cycle hold.
`timescale 1ns/1ps
module tb;
   localparam int H = 20;
   logic clk = 0, nrst = 0, standby_low = 1, main_low = 1, req = 0;
   logic standby_reset_n, main_reset_n_in, main_reset_n_out, main_reset_n_oe_n;
   int fails = 0, checks_done = 0, n;
   drp_por #(.HOLD_CYCLES(H)) u_drp_por (.*);
   drp_sys_model u_drp_sys_model (.*);
   initial forever #2 clk = ~clk;
   task automatic step(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic check(string nm, logic seen, logic exp);
      checks_done++;
      fails += (seen !== exp);
      if (seen !== exp) $display("unexpected %s exp %b seen %b", nm, exp, seen);
   endtask
   // Cycles to release; bounded so a stuck output ends the run
   task automatic meas(bit sel);
      for (n = 0; n < 99 && (sel ? main_reset_n_oe_n : standby_reset_n) !== 1'h1; n++)
         step(1);
      check("release", n < 99, 1'h1);
      if (n == 99) give_verdict;
   endtask
   task automatic give_verdict;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Standby dips mid hold; main trails the restarted hold
   task automatic t_power_up;
      standby_low = 0;
      step(H / 2);
      {standby_low, main_low} = 2'h2;
      step(8);
      standby_low = 0;
      meas(0);
      check("stby", n inside {[H + 2:H + 8]}, 1'h1);
      meas(1);
      check("main", n inside {[H:H + 4]}, 1'h1);
   endtask
   // Standby drop while all is up pulls both resets low
   task automatic t_stby_drop;
      standby_low = 1;
      step(8);
      check("stby low", standby_reset_n, 1'h0);
      check("main with stby", main_reset_n_oe_n, 1'h0);
      standby_low = 0;
      meas(0);
      check("stby again", n inside {[H + 2:H + 8]}, 1'h1);
      meas(1);
      check("main again", n inside {[H:H + 4]}, 1'h1);
   endtask
   // Lone main dip gets its own hold; standby stays up
   task automatic t_main_dip;
      main_low = 1;
      step(8);
      check("main low", main_reset_n_oe_n, 1'h0);
      check("stby kept", standby_reset_n, 1'h1);
      check("pin data", main_reset_n_out, 1'h0);
      main_low = 0;
      meas(1);
      check("main hold", n inside {[H + 2:H + 8]}, 1'h1);
   endtask
   // Outside low on the pin
   task automatic t_pin;
      req = 1;
      step(8);
      check("pin", main_reset_n_oe_n, 1'h0);
      req = 0;
      meas(1);
      check("pin hold", n inside {[H + 2:H + 8]}, 1'h1);
   endtask
   initial begin
      step(20);
      nrst = 1;
      t_power_up;
      t_pin;
      t_stby_drop;
      t_main_dip;
      give_verdict;
   end
endmodule
bind drp_por drp_por_properties u_drp_por_properties (.*);

// [rtl/drp_pkg.sv]
// Constants for the dual rail power-on reset block.
// Assumes a 250 MHz free-running clock; rail flags come from outside comparators.
package drp_pkg;
   // Clock rate and hold time
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned HOLD_MS = 180;
   // Hold period in cycles (least time, rounds up; exact here)
   localparam longint unsigned HOLD_CYC_L = (longint'(HOLD_MS) * CLK_HZ + 999) / 1000;
   localparam int unsigned HOLD_CYC = int'(HOLD_CYC_L);
   // Counter width
   localparam int unsigned CNT_W = 26;
   // Reset values
   localparam logic RST_OUT_INIT = 1'b0;
   localparam logic [2:0] SYNC_INIT = 3'h0;
   localparam logic RAIL_LOW_INIT = 1'b1;
   localparam logic EXT_LOW_INIT = 1'b0;
   localparam logic OE_N_INIT = 1'b0;
   localparam logic [CNT_W-1:0] CNT_INIT = '0;

   // Per-rail sequencer states
   typedef enum logic [2:0] {
      DRP_DOWN = 3'h1,
      DRP_HOLD = 3'h2,
      DRP_UP   = 3'h4
   } drp_state_t;
endpackage

// [rtl/drp_por.sv]
// Dual rail power-on reset sequencer: standby and main reset outputs.
// Assumes rail-low flags from asynchronous comparators and a free-running clk.
//
// Operation
// [R1] Standby reset stays low while the standby rail is below threshold.
// [R2] Standby reset releases about 180 ms after the standby rail recovers.
// [R3] Main reset stays low while the main rail is below threshold.
// [R4] Main reset releases about 180 ms after the main rail recovers.
// [R5] If main rises with or before standby, main releases 180 ms after standby.
// [R6] Main reset pin also accepts an external low as a reset request.
// [R7] A rail dip during hold re-asserts reset and restarts the full hold.
`timescale 1ns/1ps
module drp_por
   import drp_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = HOLD_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Rail comparator flags, high while the rail is below threshold
   input wire logic standby_low,
   input wire logic main_low,
   // Standby reset pin
   output logic standby_reset_n,
   // Main reset pin, open drain: in, out, enable (low while driving)
   input wire logic main_reset_n_in,
   output logic main_reset_n_out,
   output logic main_reset_n_oe_n
);

   // Three-stage synchronisers; stages 2 and 3 must agree.
   // Bit 0 is the first flop and is read only by the second.
   logic [2:0] sb_sync_q;
   logic [2:0] mn_sync_q;
   logic [2:0] ext_sync_q;

   // Filtered levels, high while the cause is present
   logic sb_low_q;
   logic mn_low_q;
   logic ext_low_q;

   // Standby rail comparator synchroniser
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sb_sync_q <= SYNC_INIT;
      end else begin
         sb_sync_q <= {sb_sync_q[1:0], standby_low};
      end
   end

   // Main rail comparator synchroniser
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mn_sync_q <= SYNC_INIT;
      end else begin
         mn_sync_q <= {mn_sync_q[1:0], main_low};
      end
   end

   // Pin sense synchroniser, inverted so high means a request
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_sync_q <= SYNC_INIT;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], ~main_reset_n_in};
      end
   end

   // Standby level filter; power-up assumes the rail low until seen otherwise
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sb_low_q <= RAIL_LOW_INIT;
      end else begin
         if (sb_sync_q[2] == sb_sync_q[1]) begin
            sb_low_q <= sb_sync_q[1];
         end
      end
   end

   // Main level filter; a one-cycle glitch never reaches the sequencer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mn_low_q <= RAIL_LOW_INIT;
      end else begin
         if (mn_sync_q[2] == mn_sync_q[1]) begin
            mn_low_q <= mn_sync_q[1];
         end
      end
   end

   // Request level filter; no request is assumed at power-up
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_low_q <= EXT_LOW_INIT;
      end else begin
         if (ext_sync_q[2] == ext_sync_q[1]) begin
            ext_low_q <= ext_sync_q[1];
         end
      end
   end

   // End of a hold; both sequencers share one terminal count, each on its own counter
   function automatic logic hold_done(input logic [CNT_W-1:0] cnt);
      hold_done = (cnt == CNT_W'(HOLD_CYCLES - 1));
   endfunction

   // Standby sequencer
   drp_state_t sb_st_q;
   logic [CNT_W-1:0] sb_cnt_q;

   // Standby state: down while low, hold while counting, up after the count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sb_st_q <= DRP_DOWN;
      end else begin
         case (sb_st_q)
            DRP_DOWN: begin
               if (!sb_low_q) begin
                  sb_st_q <= DRP_HOLD; // [R2]
               end
            end
            DRP_HOLD: begin
               if (sb_low_q) begin
                  sb_st_q <= DRP_DOWN; // [R7]
               end else if (hold_done(sb_cnt_q)) begin
                  sb_st_q <= DRP_UP; // [R2]
               end
            end
            DRP_UP: begin
               if (sb_low_q) begin
                  sb_st_q <= DRP_DOWN; // [R1]
               end
            end
            default: begin
               sb_st_q <= DRP_DOWN;
            end
         endcase
      end
   end

   // Standby counter: runs only in hold, so any exit restarts the full count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sb_cnt_q <= CNT_INIT;
      end else begin
         if ((sb_st_q != DRP_HOLD) || sb_low_q) begin
            sb_cnt_q <= CNT_INIT; // [R7]
         end else if (!hold_done(sb_cnt_q)) begin
            sb_cnt_q <= sb_cnt_q + 1'b1; // [R2]
         end
      end
   end

   // Main sequencer. Holding off while standby is not up makes a main
   // hold start only once standby has released, which covers the
   // main-first case; a lone main dip still gets its own full hold.
   drp_state_t mn_st_q;
   logic [CNT_W-1:0] mn_cnt_q;
   logic mn_block;

   // Any cause that must keep main reset low
   assign mn_block = mn_low_q | ext_low_q | (sb_st_q != DRP_UP); // [R3] [R5] [R6]

   // Main state: same shape as standby, gated by every blocking cause
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mn_st_q <= DRP_DOWN;
      end else begin
         case (mn_st_q)
            DRP_DOWN: begin
               if (!mn_block) begin
                  mn_st_q <= DRP_HOLD; // [R4] [R5]
               end
            end
            DRP_HOLD: begin
               if (mn_block) begin
                  mn_st_q <= DRP_DOWN; // [R7]
               end else if (hold_done(mn_cnt_q)) begin
                  mn_st_q <= DRP_UP; // [R4]
               end
            end
            DRP_UP: begin
               if (mn_block) begin
                  mn_st_q <= DRP_DOWN; // [R3] [R6]
               end
            end
            default: begin
               mn_st_q <= DRP_DOWN;
            end
         endcase
      end
   end

   // Main counter: cleared by any blocking cause, so a dip restarts the hold
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mn_cnt_q <= CNT_INIT;
      end else begin
         if ((mn_st_q != DRP_HOLD) || mn_block) begin
            mn_cnt_q <= CNT_INIT; // [R7]
         end else if (!hold_done(mn_cnt_q)) begin
            mn_cnt_q <= mn_cnt_q + 1'b1; // [R4]
         end
      end
   end

   // Standby output flop; the low term drops the pin one edge earlier
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         standby_reset_n <= RST_OUT_INIT;
      end else begin
         standby_reset_n <= (sb_st_q == DRP_UP) && !sb_low_q; // [R1]
      end
   end

   // Main pin data: open drain, so the data is always low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         main_reset_n_out <= RST_OUT_INIT;
      end else begin
         main_reset_n_out <= 1'b0; // [R6]
      end
   end

   // Main pin enable; released pin floats high on the pull-up.
   // The own drive reads back on the pin, so the sense must exclude it.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         main_reset_n_oe_n <= OE_N_INIT;
      end else begin
         main_reset_n_oe_n <= (mn_st_q == DRP_UP) && !mn_block; // [R3]
      end
   end

endmodule
